// file: verilog/ffs_supervisor.sv
// Purpose: Fault supervision and gate drive gating for a flyback controller
// Assumes: Comparator flags are asynchronous levels; one 40 MHz clock
// Notes:   Variant select is a static strap, synchronised like the flags
`timescale 1ns/1ps

module ffs_supervisor
	import ffs_pkg::*;
#(
	parameter longint OVLD_CYC = OVLD_CYC_L,
	parameter longint AUTOREC_CYC = AUTOREC_CYC_L
)
(
	input  wire logic CLK_IN,
	input  wire logic ARST_N_IN,
	input  wire logic OVERLOAD_IN,
	input  wire logic ABNORMAL_OVERCURRENT_PROTECT_TRIP_IN,
	input  wire logic DEMAG_ARMED_IN,
	input  wire logic DEMAG_DETECT_IN,
	input  wire logic SUPPLY_OVP_IN,
	input  wire logic THERMAL_TRIP_IN,
	input  wire logic SUPPLY_ON_IN,
	input  wire logic SUPPLY_RESET_IN,
	input  wire logic LINE_REMOVAL_IN,
	input  wire logic X2_DISCHARGE_IN,
	input  wire logic PULSE_REQUEST_IN,
	input  wire logic VALLEY_TIMEOUT_IN,
	input  wire logic PULSE_END_IN,
	input  wire logic LATCH_VARIANT_IN,
	output logic      GATE_DRIVE_PULSE_OUT,
	output logic      TIMEOUT_ENABLE_OUT,
	output logic      LATCHED_OUT,
	output logic      THERMAL_FAULT_OUT,
	output logic      AUTOREC_OUT
);

	ffs_flags_t  raw;
	ffs_flags_t  sync1;
	ffs_flags_t  flg;
	ffs_state_t  state;
	ffs_state_t  next_state;
	logic [31:0] ovld_cnt;
	logic [31:0] next_ovld_cnt;
	logic [2:0]  abnormal_overcurrent_protect_cnt;
	logic [2:0]  next_abnormal_overcurrent_protect_cnt;
	logic [11:0] on_cnt;
	logic [11:0] next_on_cnt;
	logic [31:0] ar_cnt;
	logic [31:0] next_ar_cnt;
	logic        trip_seen;
	logic        next_trip_seen;
	logic        drive;
	logic        next_drive;
	logic        thermal_pend;
	logic        next_thermal_pend;
	logic        supply_on_q;
	logic        timeout_q;
	logic        pulse_end_q;
	logic        timeout_en;
	logic        abnormal_overcurrent_protect_valid;
	logic        ovld_full;
	logic        start_ok;
	logic        end_pulse;

	// Valley timeout and pulse end come from local digital logic
	always_comb
	begin
		raw = '{OVERLOAD_IN, ABNORMAL_OVERCURRENT_PROTECT_TRIP_IN, DEMAG_ARMED_IN, DEMAG_DETECT_IN,
			SUPPLY_OVP_IN, THERMAL_TRIP_IN, SUPPLY_ON_IN, SUPPLY_RESET_IN,
			LINE_REMOVAL_IN, X2_DISCHARGE_IN, PULSE_REQUEST_IN, LATCH_VARIANT_IN};
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			sync1 <= '0;
			flg   <= '0;
		end
		else
		begin
			sync1 <= raw;
			flg   <= sync1;
		end
	end

	always_comb
	begin
		timeout_en = !flg.demag_armed;
		abnormal_overcurrent_protect_valid = drive && (on_cnt >= 12'(BLANK_CYC)) && flg.abnormal_overcurrent_protect_trip;
		ovld_full  = (ovld_cnt >= 32'(OVLD_CYC));
		// Supply on is edge qualified so a held level cannot re-arm restart
		start_ok   = flg.supply_on && !supply_on_q && !flg.supply_ovp
			&& !flg.thermal_trip && !flg.overload && !flg.supply_reset;
		end_pulse  = pulse_end_q || (on_cnt >= 12'(MAX_ON_CYC - 1));
	end

	always_comb
	begin
		next_state        = state;
		next_ovld_cnt     = ovld_cnt;
		next_abnormal_overcurrent_protect_cnt     = abnormal_overcurrent_protect_cnt;
		next_on_cnt       = on_cnt;
		next_ar_cnt       = ar_cnt;
		next_trip_seen    = trip_seen;
		next_drive        = 1'b0;
		next_thermal_pend = thermal_pend;

		if (flg.supply_reset)
			next_ovld_cnt = OVLD_RST;
		else if (flg.overload && !ovld_full)
			next_ovld_cnt = ovld_cnt + 32'h1;
		else if (!flg.overload && ovld_cnt != 32'h0)
			next_ovld_cnt = ovld_cnt - 32'h1;

		if (drive)
		begin
			next_on_cnt = on_cnt + 12'h1;
			if (abnormal_overcurrent_protect_valid)
				next_trip_seen = 1'b1;
		end

		case (state)
			FFS_OFF:
			begin
				if (start_ok)
					next_state = FFS_RUN;
			end
			FFS_RUN:
			begin
				if (drive)
					next_drive = !end_pulse && !abnormal_overcurrent_protect_valid;
				if (drive && (end_pulse || abnormal_overcurrent_protect_valid))
				begin
					next_on_cnt    = ON_RST;
					next_trip_seen = 1'b0;
					if (trip_seen || abnormal_overcurrent_protect_valid)
						next_abnormal_overcurrent_protect_cnt = abnormal_overcurrent_protect_cnt + 3'h1;
					else
						next_abnormal_overcurrent_protect_cnt = ABNORMAL_OVERCURRENT_PROTECT_RST;
				end
				else if (!drive && flg.pulse_request)
				begin
					// Armed demag blocks the timeout path entirely
					if (flg.demag_armed)
						next_drive = flg.demag_detect;
					else
						next_drive = flg.demag_detect || timeout_q;
					next_on_cnt = ON_RST;
				end
				if (flg.supply_ovp)
				begin
					next_drive = 1'b0;
					next_state = FFS_LATCH;
				end
				else if (next_abnormal_overcurrent_protect_cnt >= 3'(ABNORMAL_OVERCURRENT_PROTECT_LIMIT))
				begin
					next_drive = 1'b0;
					next_state = FFS_LATCH;
				end
				else if (flg.thermal_trip)
				begin
					next_drive        = 1'b0;
					next_thermal_pend = 1'b1;
					next_state        = FFS_THERMAL;
				end
				else if (ovld_full)
				begin
					next_drive  = 1'b0;
					next_ar_cnt = 32'h0;
					next_state  = flg.latch_variant ? FFS_LATCH : FFS_AUTOREC;
				end
				else if (flg.supply_reset)
				begin
					next_drive = 1'b0;
					next_state = FFS_OFF;
				end
			end
			FFS_LATCH:
			begin
				if (flg.supply_reset || flg.x2_discharge)
				begin
					next_abnormal_overcurrent_protect_cnt = ABNORMAL_OVERCURRENT_PROTECT_RST;
					next_state    = FFS_OFF;
				end
			end
			FFS_THERMAL:
			begin
				if (flg.supply_reset || flg.line_removal)
				begin
					next_thermal_pend = 1'b0;
					next_state        = FFS_OFF;
				end
				else if (!flg.thermal_trip)
				begin
					// Flag deasserts only after the hysteresis band is crossed
					next_thermal_pend = 1'b0;
					next_state        = FFS_WAITON;
				end
			end
			FFS_AUTOREC:
			begin
				if (ar_cnt >= 32'(AUTOREC_CYC - 1))
					next_state = FFS_WAITON;
				else
					next_ar_cnt = ar_cnt + 32'h1;
			end
			FFS_WAITON:
			begin
				if (start_ok)
					next_state = FFS_RUN;
			end
			default:
			begin
				next_state = FFS_OFF;
			end
		endcase
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			state        <= FFS_OFF;
			ovld_cnt     <= OVLD_RST;
			abnormal_overcurrent_protect_cnt     <= ABNORMAL_OVERCURRENT_PROTECT_RST;
			on_cnt       <= ON_RST;
			ar_cnt       <= 32'h0;
			trip_seen    <= 1'b0;
			drive        <= 1'b0;
			thermal_pend <= 1'b0;
			supply_on_q  <= 1'b0;
			timeout_q    <= 1'b0;
			pulse_end_q  <= 1'b0;
		end
		else
		begin
			state        <= next_state;
			ovld_cnt     <= next_ovld_cnt;
			abnormal_overcurrent_protect_cnt     <= next_abnormal_overcurrent_protect_cnt;
			on_cnt       <= next_on_cnt;
			ar_cnt       <= next_ar_cnt;
			trip_seen    <= next_trip_seen;
			drive        <= next_drive;
			thermal_pend <= next_thermal_pend;
			supply_on_q  <= flg.supply_on;
			timeout_q    <= VALLEY_TIMEOUT_IN && timeout_en;
			pulse_end_q  <= PULSE_END_IN;
		end
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			GATE_DRIVE_PULSE_OUT <= 1'b0;
			TIMEOUT_ENABLE_OUT   <= 1'b0;
			LATCHED_OUT          <= 1'b0;
			THERMAL_FAULT_OUT    <= 1'b0;
			AUTOREC_OUT          <= 1'b0;
		end
		else
		begin
			GATE_DRIVE_PULSE_OUT <= next_drive;
			TIMEOUT_ENABLE_OUT   <= timeout_en;
			LATCHED_OUT          <= (next_state == FFS_LATCH);
			THERMAL_FAULT_OUT    <= next_thermal_pend;
			AUTOREC_OUT          <= (next_state == FFS_AUTOREC);
		end
	end

endmodule // ffs_supervisor

// file: inc/ffs_pkg.sv
// Purpose: Constants and types for the flyback fault supervisor
// Assumes: 40 MHz core clock
// Notes:   Times kept in their own unit, cycle counts derived here
package ffs_pkg;
	localparam int CLK_HZ = 40000000;
	localparam int OVLD_TIME_MS = 160;
	localparam longint OVLD_CYC_L = longint'(OVLD_TIME_MS) * CLK_HZ / 1000;
	localparam int BLANK_TIME_NS = 125;
	localparam int BLANK_CYC_RAW = (BLANK_TIME_NS * 40 + 999) / 1000;
	localparam int BLANK_CYC = (BLANK_CYC_RAW < 1) ? 1 : BLANK_CYC_RAW;
	localparam int MAX_ON_US = 32;
	localparam int MAX_ON_CYC = MAX_ON_US * 40;
	localparam int AUTOREC_TIME_MS = 1200;
	localparam longint AUTOREC_CYC_L = longint'(AUTOREC_TIME_MS) * CLK_HZ / 1000;
	localparam int ABNORMAL_OVERCURRENT_PROTECT_LIMIT = 4;
	localparam logic [2:0] ABNORMAL_OVERCURRENT_PROTECT_RST = 3'h0;
	localparam logic [31:0] OVLD_RST = 32'h0;
	localparam logic [11:0] ON_RST = 12'h0;

	typedef enum logic [2:0]
	{
		FFS_OFF     = 3'b000,
		FFS_RUN     = 3'b001,
		FFS_LATCH   = 3'b010,
		FFS_THERMAL = 3'b011,
		FFS_AUTOREC = 3'b100,
		FFS_WAITON  = 3'b101
	} ffs_state_t;

	// Comparator flags and variant strap, grouped so they synchronise as one vector
	typedef struct packed
	{
		logic overload;
		logic abnormal_overcurrent_protect_trip;
		logic demag_armed;
		logic demag_detect;
		logic supply_ovp;
		logic thermal_trip;
		logic supply_on;
		logic supply_reset;
		logic line_removal;
		logic x2_discharge;
		logic pulse_request;
		logic latch_variant;
	} ffs_flags_t;
endpackage

// file: tb/ffs_chk.sv
// Purpose: Port checks for the fault supervisor
// Assumes: Flags act within five edges
// Notes:   Bound from tb_top
`timescale 1ns/1ps
module ffs_chk
	import ffs_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic SUPPLY_OVP_IN,
	input wire logic THERMAL_TRIP_IN,
	input wire logic DEMAG_ARMED_IN,
	input wire logic SUPPLY_RESET_IN,
	input wire logic X2_DISCHARGE_IN,
	input wire logic GATE_DRIVE_PULSE_OUT,
	input wire logic TIMEOUT_ENABLE_OUT,
	input wire logic LATCHED_OUT,
	input wire logic THERMAL_FAULT_OUT,
	input wire logic AUTOREC_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	wire logic   g = GATE_DRIVE_PULSE_OUT;
	logic [11:0] on_n;
	logic [5:0]  ex_h;
	// History window covers the flag synchroniser delay
	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
		if (!ARST_N_IN)
		begin
			on_n <= 12'h0;
			ex_h <= 6'h0;
		end
		else
		begin
			on_n <= g ? on_n + 12'h1 : 12'h0;
			ex_h <= {ex_h[4:0], SUPPLY_RESET_IN | X2_DISCHARGE_IN};
		end
	AST_OVP_STOP: assert property (SUPPLY_OVP_IN [*5] |-> !g)
		else $error("gate on in overvoltage");
	AST_THERM_STOP: assert property (THERMAL_TRIP_IN [*5] |-> !g)
		else $error("gate on when hot");
	AST_MAX_ON: assert property (on_n <= 12'(MAX_ON_CYC + 1))
		else $error("on-time too long");
	AST_LATCH_EXIT: assert property ($fell(LATCHED_OUT) |-> |ex_h)
		else $error("latch left without cause");
	AST_LATCH_GATE: assert property (LATCHED_OUT [*2] |-> !g)
		else $error("gate on while latched");
	AST_THERM_GATE: assert property (THERMAL_FAULT_OUT [*2] |-> !g)
		else $error("gate on in thermal fault");
	AST_AREC_GATE: assert property (AUTOREC_OUT [*2] |-> !g)
		else $error("gate on in recovery");
	AST_TMO_OFF: assert property (DEMAG_ARMED_IN [*5] |-> !TIMEOUT_ENABLE_OUT)
		else $error("timeout live while armed");
endmodule // ffs_chk

// file: tb/ffs_stage.sv
// Purpose: Power stage and sense comparators
// Assumes: Mode 0 normal, 1 winding short, 2 sense shorted
// Notes:   Demag rings once per 64 idle cycles
`timescale 1ns/1ps
module ffs_stage
(
	input  wire logic       clk,
	input  wire logic       gate,
	input  wire logic [1:0] mode,
	output logic            pulse_end = 1'b0,
	output logic            abnormal_overcurrent_protect = 1'b0,
	output logic            demag = 1'b0
);
	int   cnt  = 0;
	logic last = 1'b0;
	always @(negedge clk)
	begin
		cnt <= (gate != last) ? 0 : cnt + 1;
		last <= gate;
		pulse_end <= gate && mode == 2'h0 && cnt > 12;
		abnormal_overcurrent_protect <= gate && mode == 2'h1;
		demag <= !gate && cnt[5:3] == 3'h1;
	end
endmodule // ffs_stage

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the fault supervisor
// Assumes: Short overload and recovery counts
// Notes:   Status changes compared in order
`timescale 1ns/1ps
module tb_top
	import ffs_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	ffs_flags_t f = '0;
	logic       vt = 1'b0;
	logic [1:0] mode = 2'h0;
	logic       pe, ao, dm, gate;
	logic [2:0] st;
	logic [2:0] st_d = 3'h0;
	logic [2:0] exp_q[$];
	int         fail_count = 0;
	int         n_compared = 0;
	int         cyc = 0;
	always #12.5 clk = ~clk;
	ffs_supervisor #(.OVLD_CYC(50), .AUTOREC_CYC(100)) i_dut (
		.CLK_IN(clk),
		.ARST_N_IN(rst_n),
		.OVERLOAD_IN(f.overload),
		.ABNORMAL_OVERCURRENT_PROTECT_TRIP_IN(ao),
		.DEMAG_ARMED_IN(f.demag_armed),
		.DEMAG_DETECT_IN(dm),
		.SUPPLY_OVP_IN(f.supply_ovp),
		.THERMAL_TRIP_IN(f.thermal_trip),
		.SUPPLY_ON_IN(f.supply_on),
		.SUPPLY_RESET_IN(f.supply_reset),
		.LINE_REMOVAL_IN(f.line_removal),
		.X2_DISCHARGE_IN(f.x2_discharge),
		.PULSE_REQUEST_IN(f.pulse_request),
		.VALLEY_TIMEOUT_IN(vt),
		.PULSE_END_IN(pe),
		.LATCH_VARIANT_IN(f.latch_variant),
		.GATE_DRIVE_PULSE_OUT(gate),
		.TIMEOUT_ENABLE_OUT(),
		.LATCHED_OUT(st[2]),
		.THERMAL_FAULT_OUT(st[1]),
		.AUTOREC_OUT(st[0])
	);
	ffs_stage i_stage (.clk(clk), .gate(gate), .mode(mode), .pulse_end(pe), .abnormal_overcurrent_protect(ao), .demag(dm));
	task automatic check_st(input logic [2:0] e, input logic [2:0] a);
		n_compared++;
		if (a !== e)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task automatic stop_test();
		fail_count += exp_q.size();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulses(input logic [1:0] m, input int n);
		mode = m;
		repeat (n) @(negedge gate);
	endtask
	task automatic power_on();
		f.supply_reset = 1'b1;
		f.supply_on = 1'b0;
		cycles(6);
		f.supply_reset = 1'b0;
		cycles(6);
		f.supply_on = 1'b1;
		cycles(6);
	endtask
	// Sparse timeouts so most pulses wait for demag
	// Requests drop out now and then so the wait path is exercised
	always @(negedge clk)
	begin
		vt <= ($urandom % 40) == 0;
		f.pulse_request <= ($urandom % 8) != 0;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		st_d <= st;
		if (st !== st_d)
			check_st(exp_q.size() ? exp_q.pop_front() : 3'h7, st);
		if (cyc == 20000)
		begin
			fail_count++;
			stop_test();
		end
	end
	initial
	begin
		void'($urandom(17));
		cycles(16);
		rst_n = 1'b1;
		power_on();
		repeat (8)
		begin
			f.demag_armed = 1'($urandom);
			cycles(150);
		end
		f.demag_armed = 1'b0;
		pulses(2'h2, 2);
		$display("switching done");
		pulses(2'h1, 3);
		pulses(2'h0, 1);
		pulses(2'h1, 3);
		pulses(2'h0, 1);
		exp_q.push_back(3'h4);
		pulses(2'h1, 4);
		// Back to a healthy stage before the next restart
		mode = 2'h0;
		cycles(10);
		exp_q.push_back(3'h0);
		f.x2_discharge = 1'b1;
		cycles(6);
		f.x2_discharge = 1'b0;
		power_on();
		exp_q.push_back(3'h4);
		f.supply_ovp = !f.supply_ovp;
		cycles(10);
		f.supply_ovp = !f.supply_ovp;
		cycles(10);
		exp_q.push_back(3'h0);
		power_on();
		$display("latch done");
		exp_q.push_back(3'h2);
		f.thermal_trip = !f.thermal_trip;
		cycles(10);
		exp_q.push_back(3'h0);
		f.thermal_trip = !f.thermal_trip;
		cycles(10);
		power_on();
		exp_q.push_back(3'h2);
		f.thermal_trip = !f.thermal_trip;
		cycles(10);
		exp_q.push_back(3'h0);
		f.line_removal = 1'($urandom % 2);
		f.supply_reset = !f.line_removal;
		cycles(6);
		f.line_removal = 1'b0;
		f.supply_reset = 1'b0;
		f.thermal_trip = !f.thermal_trip;
		cycles(6);
		$display("thermal done");
		for (int v = 1; v >= 0; v--)
		begin
			f.latch_variant = v[0];
			power_on();
			f.overload = !f.overload;
			cycles(40);
			f.overload = !f.overload;
			cycles(60);
			f.overload = !f.overload;
			cycles(45);
			exp_q.push_back(v ? 3'h4 : 3'h1);
			cycles(30);
			f.overload = !f.overload;
			// Latch is left at the next supply reset, recovery by its timer
			exp_q.push_back(3'h0);
			cycles(150);
		end
		$display("overload done");
		stop_test();
	end
endmodule // tb_top
bind ffs_supervisor ffs_chk i_chk (.*);
